// ==== core/sched_defines.svh ====
// Timing and sizing constants of the superframe scheduler.
`ifndef SCHED_DEFINES_SVH
`define SCHED_DEFINES_SVH

`define SLOTS_PER_SF 9'h100
`define MCLK_PERIOD_NS 50
`define SLOT_TIME_NS 256000
`define SLOT_CYCLES (`SLOT_TIME_NS / `MCLK_PERIOD_NS)
`define ACK_WAIT_NS 20000
`define ACK_CYCLES ((`ACK_WAIT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define MAX_RETRY 4'h3
`define MIN_BP_SLOTS 8'h01

`endif

// ==== core/sched_pkg.sv ====
// Types shared by the superframe scheduler modules.
package sched_pkg;

  typedef enum logic [1:0] {
    ROLE_MASTER,
    ROLE_SLAVE,
    ROLE_PEER
  } role_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_SCAN,
    ST_RUN
  } ctl_state_t;

  typedef enum logic [1:0] {
    PER_BEACON,
    PER_SIGNAL,
    PER_DATA,
    PER_CONTENTION
  } period_t;

  typedef enum logic [1:0] {
    ACK_NONE,
    ACK_IMM,
    ACK_BLK
  } ack_pol_t;

endpackage

// ==== core/sf_scheduler.sv ====
// Superframe scheduler: channel start-up, periods, access gating, labels and acks.
//
// Operation
// [RQ1] A superframe holds 256 slots of the configured slot length.
// [RQ2] Every superframe opens with a beacon period of at least one slot.
// [RQ3] Beacon period, then data transfer period, then contention signalling window.
// [RQ4] Master-slave mode may add a signalling window after beacons; peers never.
// [RQ5] Beacon period length follows the count of regular beaconing devices.
// [RQ6] All devices on one channel share one superframe structure, merging differing ones.
// [RQ7] With a clear empty channel, a master or peer starts its own beacon period.
// [RQ8] Detected beacons make the device align its beacon period to them.
// [RQ9] Data is exchanged on the channel chosen for beaconing.
// [RQ10] An enabled slave scans channels for a master beacon, then joins it.
// [RQ11] Masters and peers beacon by default; slaves only when promoted.
// [RQ12] A slave can beacon regularly once the master promotes it.
// [RQ13] Awake through beacon period and contention window; data period may sleep.
// [RQ14] Only beacons are sent in own or neighbour beacon periods.
// [RQ15] A foreign unaligned beacon period is recorded and announced for protection.
// [RQ16] Nothing is transmitted in a scheduled quiet period.
// [RQ17] During a reservation only its participants transmit.
// [RQ18] Elsewhere frames may use prioritized contention access.
// [RQ19] Fragments carry the data unit sequence number and a fragment number.
// [RQ20] Immediate policy acknowledges each received frame at once.
// [RQ21] Block policy acknowledges a group only when the source asks.
// [RQ22] A missing acknowledgement leads to a retransmission or a discard.
// [RQ23] The slot counter advances per slot and wraps to zero.
`timescale 1ns/1ps
`include "sched_defines.svh"

module sf_scheduler #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input sched_pkg::role_t role,
  input wire logic promote,
  input wire logic merge_en,
  input wire logic [5:0] first_chan,
  input wire logic [5:0] last_chan,
  input wire logic [7:0] beacon_devices,
  input wire logic [7:0] own_beacon_slot,
  input wire logic rsw_en,
  input wire logic [7:0] rsw_len,
  input wire logic [7:0] csw_len,
  input wire logic quiet_en,
  input wire logic [7:0] quiet_start,
  input wire logic [7:0] quiet_len,
  input wire logic resv_active,
  input wire logic resv_member,
  input wire logic data_awake_req,
  input wire logic phy_beacon,
  input wire logic phy_master,
  input wire logic phy_aligned,
  input wire logic phy_incumbent,
  input wire logic frag_sent,
  input wire logic frag_last,
  input wire logic tx_frame_done,
  input sched_pkg::ack_pol_t tx_ack_pol,
  input wire logic tx_blk_req,
  input wire logic tx_no_retry,
  input wire logic rx_ack,
  input wire logic rx_frame_ok,
  input sched_pkg::ack_pol_t rx_ack_pol,
  input wire logic rx_blk_req,
  output logic operating,
  output logic [5:0] channel,
  output logic beaconing,
  output logic [7:0] slot_index,
  output logic sf_start,
  output sched_pkg::period_t period,
  output logic awake,
  output logic tx_beacon,
  output logic tx_contention,
  output logic tx_reserved,
  output logic alien_announce,
  output logic [7:0] alien_slot,
  output logic [11:0] seq_num,
  output logic [3:0] frag_num,
  output logic send_imm_ack,
  output logic send_blk_ack,
  output logic ack_wait,
  output logic retransmit,
  output logic discard
);

  localparam logic [8:0] ACK_LAST = 9'(`ACK_CYCLES - 1);

  typedef struct packed {
    sched_pkg::ctl_state_t st;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic bcn_d;
    logic align;
    logic [5:0] chan;
    logic bcn_en;
    logic [7:0] bp_len;
    logic [7:0] slot;
    logic sf;
    sched_pkg::period_t per;
    logic awake;
    logic tx_bcn;
    logic tx_cont;
    logic tx_resv;
    logic alien_valid;
    logic [7:0] alien_slot;
    logic [11:0] seq;
    logic [3:0] frag;
    logic send_ack;
    logic send_back;
    logic ack_wait;
    logic [8:0] ack_cnt;
    logic [3:0] retry;
    logic retx;
    logic drop;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [7:0] tm_slot;
  logic tm_sf;

  slot_timer #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .run(st_reg.st != sched_pkg::ST_OFF),
    .align(st_reg.align),
    .slot_idx(tm_slot),
    .slot_tick(),
    .sf_tick(tm_sf)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic bcn_new;
    logic run;
    logic quiet;
    logic alien_hit;
    logic ms_mode;
    logic [8:0] sig_end;
    logic [8:0] quiet_end;
    sched_pkg::period_t per;
    bcn_new = 1'b0;
    run = 1'b0;
    quiet = 1'b0;
    alien_hit = 1'b0;
    ms_mode = 1'b0;
    sig_end = 9'h000;
    quiet_end = 9'h000;
    per = sched_pkg::PER_DATA;

    st_next = st_reg;
    // Pin levels pass two flops; edges are taken between the second and third.
    st_next.sy1 = {phy_incumbent, phy_aligned, phy_master, phy_beacon};
    st_next.sy2 = st_reg.sy1;
    st_next.bcn_d = st_reg.sy2[0];
    st_next.align = 1'b0;
    st_next.send_ack = 1'b0;
    st_next.send_back = 1'b0;
    st_next.retx = 1'b0;
    st_next.drop = 1'b0;
    bcn_new = st_reg.sy2[0] & ~st_reg.bcn_d;

    unique case (st_reg.st)
      sched_pkg::ST_OFF: begin
        if (enable) begin
          st_next.st = sched_pkg::ST_SCAN;
          st_next.chan = first_chan;
          st_next.bcn_en = 1'b0;
          st_next.alien_valid = 1'b0;
          st_next.bp_len = `MIN_BP_SLOTS;
        end
      end
      sched_pkg::ST_SCAN: begin
        if (!enable) begin
          st_next.st = sched_pkg::ST_OFF;
        end else if (bcn_new && (role != sched_pkg::ROLE_SLAVE || st_reg.sy2[1])) begin
          // Join the beacons found here and keep this channel for data. [RQ8] [RQ9] [RQ10]
          st_next.st = sched_pkg::ST_RUN;
          st_next.align = 1'b1;
        end else if (tm_sf) begin
          if (!st_reg.sy2[3] && role != sched_pkg::ROLE_SLAVE) begin
            // A whole superframe passed with no beacon and no incumbent. [RQ7]
            st_next.st = sched_pkg::ST_RUN;
            st_next.align = 1'b1;
          end else begin
            // A slave moves on until it hears its master. [RQ10]
            st_next.chan = (st_reg.chan == last_chan) ? first_chan : st_reg.chan + 6'h01;
          end
        end
      end
      sched_pkg::ST_RUN: begin
        if (!enable) begin
          st_next.st = sched_pkg::ST_OFF;
        end else if (bcn_new && !st_reg.sy2[2]) begin
          if (merge_en) begin
            // Adopt the other network's superframe timing. [RQ6]
            st_next.align = 1'b1;
            st_next.alien_valid = 1'b0;
          end else begin
            st_next.alien_valid = 1'b1; // [RQ15]
            st_next.alien_slot = tm_slot;
          end
        end
      end
    endcase

    // Masters and peers beacon by default, a slave once promoted. [RQ11] [RQ12]
    st_next.bcn_en = (st_next.st == sched_pkg::ST_RUN) && (role != sched_pkg::ROLE_SLAVE || promote);

    // The beacon period length is taken only at a superframe start. [RQ5]
    if (tm_sf) begin
      st_next.bp_len = (beacon_devices == 8'h00) ? `MIN_BP_SLOTS : beacon_devices;
    end

    ////////////////////////////////////////////////////////////////////////////

    run = (st_reg.st == sched_pkg::ST_RUN);
    ms_mode = (role != sched_pkg::ROLE_PEER);
    sig_end = {1'b0, st_reg.bp_len} + {1'b0, rsw_len};
    quiet_end = {1'b0, quiet_start} + {1'b0, quiet_len};
    quiet = quiet_en && (tm_slot >= quiet_start) && ({1'b0, tm_slot} < quiet_end);
    alien_hit = st_reg.alien_valid && (tm_slot == st_reg.alien_slot);

    if (tm_slot < st_reg.bp_len) begin
      per = sched_pkg::PER_BEACON; // [RQ2]
    end else if (ms_mode && rsw_en && ({1'b0, tm_slot} < sig_end)) begin
      per = sched_pkg::PER_SIGNAL; // [RQ4]
    end else if ({1'b0, tm_slot} >= (`SLOTS_PER_SF - {1'b0, csw_len})) begin
      per = sched_pkg::PER_CONTENTION; // [RQ3]
    end else begin
      per = sched_pkg::PER_DATA; // [RQ3]
    end

    st_next.slot = tm_slot;
    st_next.sf = run && tm_sf;
    st_next.per = per;
    // Awake throughout a scan; while running, awake outside the data period. [RQ13]
    st_next.awake = (st_reg.st == sched_pkg::ST_SCAN) ||
                    (run && (per != sched_pkg::PER_DATA || data_awake_req));
    // Only the own beacon in the beacon period, never while quiet. [RQ14] [RQ16]
    st_next.tx_bcn = run && st_reg.bcn_en && per == sched_pkg::PER_BEACON &&
                     tm_slot == own_beacon_slot && !quiet;
    // Contention access in the data period and contention window, outside reservations. [RQ14] [RQ16] [RQ18]
    st_next.tx_cont = run && !quiet && !alien_hit && !resv_active &&
                      (per == sched_pkg::PER_DATA || per == sched_pkg::PER_CONTENTION);
    // A reservation is used only by its members. [RQ14] [RQ16] [RQ17]
    st_next.tx_resv = run && !quiet && !alien_hit && resv_active && resv_member &&
                      (per == sched_pkg::PER_DATA || per == sched_pkg::PER_SIGNAL);

    ////////////////////////////////////////////////////////////////////////////

    // Fragments share the unit's sequence number and count up from zero. [RQ19]
    if (frag_sent) begin
      if (frag_last) begin
        st_next.seq = st_reg.seq + 12'h001;
        st_next.frag = 4'h0;
      end else begin
        st_next.frag = st_reg.frag + 4'h1;
      end
    end

    if (rx_frame_ok && rx_ack_pol == sched_pkg::ACK_IMM) begin
      st_next.send_ack = 1'b1; // [RQ20]
    end
    if (rx_frame_ok && rx_ack_pol == sched_pkg::ACK_BLK && rx_blk_req) begin
      st_next.send_back = 1'b1; // [RQ21]
    end

    if (st_reg.ack_wait) begin
      if (rx_ack) begin
        st_next.ack_wait = 1'b0;
        st_next.retry = 4'h0;
      end else if (st_reg.ack_cnt == 9'h000) begin
        // Retry while attempts remain and the frame allows it, else discard. [RQ22]
        st_next.ack_wait = 1'b0;
        if (!tx_no_retry && st_reg.retry < `MAX_RETRY) begin
          st_next.retx = 1'b1;
          st_next.retry = st_reg.retry + 4'h1;
        end else begin
          st_next.drop = 1'b1;
          st_next.retry = 4'h0;
        end
      end else begin
        st_next.ack_cnt = st_reg.ack_cnt - 9'h001;
      end
    end else if (tx_frame_done && (tx_ack_pol == sched_pkg::ACK_IMM ||
                                   (tx_ack_pol == sched_pkg::ACK_BLK && tx_blk_req))) begin
      // Wait only when an acknowledgement was requested. [RQ20] [RQ21]
      st_next.ack_wait = 1'b1;
      st_next.ack_cnt = ACK_LAST;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign operating = (st_reg.st == sched_pkg::ST_RUN);
  assign channel = st_reg.chan;
  assign beaconing = st_reg.bcn_en;
  assign slot_index = st_reg.slot;
  assign sf_start = st_reg.sf;
  assign period = st_reg.per;
  assign awake = st_reg.awake;
  assign tx_beacon = st_reg.tx_bcn;
  assign tx_contention = st_reg.tx_cont;
  assign tx_reserved = st_reg.tx_resv;
  assign alien_announce = st_reg.alien_valid;
  assign alien_slot = st_reg.alien_slot;
  assign seq_num = st_reg.seq;
  assign frag_num = st_reg.frag;
  assign send_imm_ack = st_reg.send_ack;
  assign send_blk_ack = st_reg.send_back;
  assign ack_wait = st_reg.ack_wait;
  assign retransmit = st_reg.retx;
  assign discard = st_reg.drop;

endmodule // sf_scheduler

// ==== core/slot_timer.sv ====
// Slot timer: cycles within a slot and the slot index within a superframe.
`timescale 1ns/1ps
`include "sched_defines.svh"

module slot_timer #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic align,
  output logic [7:0] slot_idx,
  output logic slot_tick,
  output logic sf_tick
);

  localparam logic [19:0] LAST_CYC = 20'(SLOT_CYCLES - 1);

  typedef struct packed {
    logic [19:0] cyc;
    logic [7:0] slot;
    logic tick;
    logic sf;
  } tmr_t;

  tmr_t tmr_reg;
  tmr_t tmr_next;

  always_comb begin
    tmr_next = tmr_reg;
    tmr_next.tick = 1'b0;
    tmr_next.sf = 1'b0;
    if (!run) begin
      tmr_next = '0;
    end else if (align) begin
      tmr_next.cyc = 20'h00000;
      tmr_next.slot = 8'h00;
      tmr_next.tick = 1'b1;
      tmr_next.sf = 1'b1;
    end else if (tmr_reg.cyc == LAST_CYC) begin
      // The slot index wraps from the last slot back to zero. [RQ1] [RQ23]
      tmr_next.cyc = 20'h00000;
      tmr_next.slot = tmr_reg.slot + 8'h01;
      tmr_next.tick = 1'b1;
      tmr_next.sf = (tmr_reg.slot == 8'hFF);
    end else begin
      tmr_next.cyc = tmr_reg.cyc + 20'h00001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tmr_reg <= '0;
    end else if (ce) begin
      tmr_reg <= tmr_next;
    end
  end

  assign slot_idx = tmr_reg.slot;
  assign slot_tick = tmr_reg.tick;
  assign sf_tick = tmr_reg.sf;

endmodule // slot_timer

// ==== tb/phy_peer_model.sv ====
// Far-side device that sends one beacon into the scheduler's phy pins on request.
`timescale 1ns/1ps
module phy_peer_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic is_master,
  input wire logic is_aligned,
  input wire logic incumbent,
  output logic phy_beacon,
  output logic phy_master,
  output logic phy_aligned,
  output logic phy_incumbent
);
  logic [3:0] cnt_reg = 4'h0;
  logic [1:0] qual_reg = 2'h0;
  // Qualifiers stay steady around the beacon and change every cycle while the beacon counter is idle.
  always @(posedge mclk) begin
    if (go) begin
      cnt_reg <= 4'h1;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
    qual_reg <= (go || cnt_reg != 4'h0) ? {is_master, is_aligned} : ~qual_reg;
  end
  assign phy_beacon = cnt_reg >= 4'h4 && cnt_reg <= 4'hB;
  assign phy_master = qual_reg[1];
  assign phy_aligned = qual_reg[0];
  assign phy_incumbent = incumbent;
endmodule // phy_peer_model

// ==== tb/sf_scheduler_monitor.sv ====
// Port-level checker of the superframe scheduler.
`timescale 1ns/1ps
module sf_scheduler_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic operating,
  input wire logic [7:0] slot_index,
  input sched_pkg::period_t period,
  input wire logic awake,
  input wire logic tx_beacon,
  input wire logic tx_contention,
  input wire logic tx_reserved,
  input wire logic frag_sent,
  input wire logic frag_last,
  input wire logic [3:0] frag_num,
  input wire logic rx_frame_ok,
  input sched_pkg::ack_pol_t rx_ack_pol,
  input wire logic rx_blk_req,
  input wire logic send_imm_ack,
  input wire logic send_blk_ack,
  input wire logic rx_ack,
  input wire logic ack_wait,
  input wire logic retransmit,
  input wire logic discard,
  input wire logic sf_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  imm_ack_a: assert property (ce && rx_frame_ok && rx_ack_pol == sched_pkg::ACK_IMM |=> send_imm_ack)
    else $error("immediate ack missing");
  blk_ack_a: assert property (ce && rx_frame_ok && rx_ack_pol == sched_pkg::ACK_BLK && rx_blk_req |=> send_blk_ack)
    else $error("block ack missing");
  blk_unasked_a: assert property (rx_frame_ok && rx_ack_pol == sched_pkg::ACK_BLK && !rx_blk_req |=> !send_blk_ack)
    else $error("block ack sent unasked");
  frag_step_a: assert property (ce && frag_sent && !frag_last |=> frag_num == $past(frag_num) + 4'h1)
    else $error("fragment number did not step");
  beacon_only_a: assert property (tx_beacon |-> period == sched_pkg::PER_BEACON && !tx_contention && !tx_reserved)
    else $error("beacon permission outside beacon period");
  contention_ok_a: assert property (tx_contention |-> period inside {sched_pkg::PER_DATA, sched_pkg::PER_CONTENTION})
    else $error("contention permission in wrong period");
  stay_awake_a: assert property (operating && period inside {sched_pkg::PER_BEACON, sched_pkg::PER_CONTENTION} |-> awake)
    else $error("asleep in beacon or contention period");
  slot_step_a: assert property (operating ##1 (operating && slot_index != $past(slot_index)) |->
    slot_index == $past(slot_index) + 8'h01 || slot_index == 8'h00)
    else $error("slot index skipped");
  ack_expiry_a: assert property (ce && $fell(ack_wait) && !$past(rx_ack) |-> retransmit || discard)
    else $error("ack wait ended without retry or discard");
  sf_c: cover property (sf_start);
  retry_c: cover property (retransmit);
  discard_c: cover property (discard);
  blk_c: cover property (send_blk_ack);
endmodule // sf_scheduler_monitor

// ==== tb/tb_sf_scheduler.sv ====
// Self-checking bench of the superframe scheduler.
`timescale 1ns/1ps
module tb_sf_scheduler;
  localparam int SC = 4;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, enable = 1'b0, promote = 1'b0, merge_en = 1'b0;
  sched_pkg::role_t role = sched_pkg::ROLE_MASTER;
  logic [5:0] first_chan = 6'h05, last_chan = 6'h07, channel;
  logic [7:0] beacon_devices = 8'h02, own_beacon_slot = 8'h01, rsw_len = 8'h03, csw_len = 8'h08;
  logic [7:0] quiet_start = 8'h64, quiet_len = 8'h02, slot_index, alien_slot;
  logic rsw_en = 1'b1, quiet_en = 1'b1, resv_active = 1'b0, resv_member = 1'b0, data_awake_req = 1'b0;
  logic frag_sent = 1'b0, frag_last = 1'b0, tx_frame_done = 1'b0, tx_blk_req = 1'b0, tx_no_retry = 1'b0;
  logic rx_ack = 1'b0, rx_frame_ok = 1'b0, rx_blk_req = 1'b0;
  sched_pkg::ack_pol_t tx_ack_pol = sched_pkg::ACK_IMM, rx_ack_pol = sched_pkg::ACK_NONE;
  logic go = 1'b0, is_master = 1'b1, is_aligned = 1'b1, incumbent = 1'b0;
  logic phy_beacon, phy_master, phy_aligned, phy_incumbent;
  logic operating, beaconing, sf_start, awake, tx_beacon, tx_contention, tx_reserved, alien_announce;
  logic send_imm_ack, send_blk_ack, ack_wait, retransmit, discard;
  logic [11:0] seq_num;
  logic [3:0] frag_num;
  sched_pkg::period_t period;
  int failures = 0, n_checks = 0, cyc = 0;

  always #25 mclk = ~mclk;

  phy_peer_model i_phy_peer_model (.mclk, .go, .is_master, .is_aligned, .incumbent,
    .phy_beacon, .phy_master, .phy_aligned, .phy_incumbent);

  sf_scheduler #(.SLOT_CYCLES(SC)) i_sf_scheduler (.mclk, .rst, .ce, .enable, .role, .promote, .merge_en,
    .first_chan, .last_chan, .beacon_devices, .own_beacon_slot, .rsw_en, .rsw_len, .csw_len, .quiet_en,
    .quiet_start, .quiet_len, .resv_active, .resv_member, .data_awake_req, .phy_beacon, .phy_master,
    .phy_aligned, .phy_incumbent, .frag_sent, .frag_last, .tx_frame_done, .tx_ack_pol, .tx_blk_req,
    .tx_no_retry, .rx_ack, .rx_frame_ok, .rx_ack_pol, .rx_blk_req, .operating, .channel, .beaconing,
    .slot_index, .sf_start, .period, .awake, .tx_beacon, .tx_contention, .tx_reserved, .alien_announce,
    .alien_slot, .seq_num, .frag_num, .send_imm_ack, .send_blk_ack, .ack_wait, .retransmit, .discard);

  ////////////////////////////////////////
  task automatic end_of_test;
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic t_start;
    int n;
    int pc[4];
    int nb;
    int nc;
    pc = '{0, 0, 0, 0};
    nb = 0;
    nc = 0;
    n = 0;
    @(posedge mclk) enable <= 1'b1;
    while (operating !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    chk("operating", 16'h1, 16'(operating));
    chk("beaconing", 16'h1, 16'(beaconing));
    chk("channel", 16'h0005, 16'(channel));
    n = 0;
    while (sf_start !== 1'b1 && n < 1100) begin
      @(negedge mclk);
      n++;
    end
    repeat (1024) begin
      pc[period]++;
      nb += int'(tx_beacon);
      nc += int'(tx_contention);
      @(negedge mclk);
    end
    chk("beacon_cycles", 16'h0008, 16'(pc[0]));
    chk("signal_cycles", 16'h000C, 16'(pc[1]));
    chk("data_cycles", 16'h03CC, 16'(pc[2]));
    chk("contention_cycles", 16'h0020, 16'(pc[3]));
    chk("tx_beacon_cycles", 16'h0004, 16'(nb));
    chk("tx_contention_cycles", 16'h03E4, 16'(nc));
  endtask

  task automatic t_frag;
    @(posedge mclk) frag_sent <= 1'b1;
    @(posedge mclk) frag_last <= 1'b1;
    @(negedge mclk) chk("frag_num", 16'h0001, 16'(frag_num));
    @(posedge mclk) frag_sent <= 1'b0;
    frag_last <= 1'b0;
    @(negedge mclk) chk("frag_num", 16'h0000, 16'(frag_num));
    chk("seq_num", 16'h0001, 16'(seq_num));
  endtask

  task automatic t_rxack;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) rx_frame_ok <= 1'b1;
      rx_ack_pol <= (i == 3) ? sched_pkg::ACK_BLK : sched_pkg::ack_pol_t'(i);
      rx_blk_req <= (i != 3);
      @(posedge mclk) rx_frame_ok <= 1'b0;
      @(negedge mclk) chk("send_imm_ack", 16'(i == 1), 16'(send_imm_ack));
      chk("send_blk_ack", 16'(i == 2), 16'(send_blk_ack));
    end
  endtask

  task automatic send_frame;
    @(posedge mclk) tx_frame_done <= 1'b1;
    @(posedge mclk) tx_frame_done <= 1'b0;
    @(negedge mclk) chk("ack_wait", 16'h1, 16'(ack_wait));
  endtask

  task automatic await_end(input int k_retry);
    int n;
    n = 0;
    while (!(retransmit || discard) && n < 500) begin
      @(negedge mclk);
      n++;
    end
    chk("ack_wait_cycles", 16'h0190, 16'(n));
    chk("retransmit", 16'(k_retry), 16'(retransmit));
    chk("discard", 16'(!k_retry), 16'(discard));
  endtask

  task automatic t_txack;
    for (int k = 0; k < 4; k++) begin
      send_frame();
      await_end(int'(k < 3));
    end
    @(posedge mclk) tx_no_retry <= 1'b1;
    send_frame();
    await_end(0);
    @(posedge mclk) tx_no_retry <= 1'b0;
    tx_ack_pol <= sched_pkg::ACK_BLK;
    tx_blk_req <= 1'b1;
    send_frame();
    repeat (9) @(posedge mclk);
    rx_ack <= 1'b1;
    @(posedge mclk) rx_ack <= 1'b0;
    @(negedge mclk) chk("ack_wait", 16'h0, 16'(ack_wait));
  endtask

  task automatic t_access;
    int n;
    n = 0;
    while (slot_index !== 8'h0A && n < 1100) begin
      @(negedge mclk);
      n++;
    end
    chk("awake", 16'h0, 16'(awake));
    @(posedge mclk) resv_active <= 1'b1;
    resv_member <= 1'b1;
    data_awake_req <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk) chk("tx_reserved", 16'h1, 16'(tx_reserved));
    chk("tx_contention", 16'h0, 16'(tx_contention));
    chk("awake", 16'h1, 16'(awake));
    @(posedge mclk) resv_member <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk) chk("tx_reserved", 16'h0, 16'(tx_reserved));
    chk("tx_contention", 16'h0, 16'(tx_contention));
    @(posedge mclk) resv_active <= 1'b0;
    data_awake_req <= 1'b0;
    is_master <= 1'b0;
    is_aligned <= 1'b0;
    go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    n = 0;
    while (alien_announce !== 1'b1 && n < 30) begin
      @(negedge mclk);
      n++;
    end
    chk("alien_announce", 16'h1, 16'(alien_announce));
    chk("alien_slot", 16'(slot_index), 16'(alien_slot));
    repeat (20) @(posedge mclk);
    merge_en <= 1'b1;
    go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    n = 0;
    while (sf_start !== 1'b1 && n < 30) begin
      @(negedge mclk);
      n++;
    end
    chk("sf_start", 16'h1, 16'(sf_start));
    chk("alien_announce", 16'h0, 16'(alien_announce));
    chk("slot_index", 16'h0000, 16'(slot_index));
    @(posedge mclk) role <= sched_pkg::ROLE_PEER;
    merge_en <= 1'b0;
    is_master <= 1'b1;
    is_aligned <= 1'b1;
    n = 0;
    while (slot_index !== 8'h03 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk("period", 16'(sched_pkg::PER_DATA), 16'(period));
  endtask

  task automatic t_join;
    int n;
    n = 0;
    @(posedge mclk) enable <= 1'b0;
    role <= sched_pkg::ROLE_SLAVE;
    repeat (3) @(posedge mclk);
    enable <= 1'b1;
    repeat (4) @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    while (operating !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk("operating", 16'h1, 16'(operating));
    chk("beaconing", 16'h0, 16'(beaconing));
    chk("channel", 16'h0005, 16'(channel));
    @(posedge mclk) promote <= 1'b1;
    n = 0;
    while (beaconing !== 1'b1 && n < 1100) begin
      @(negedge mclk);
      n++;
    end
    chk("beaconing", 16'h1, 16'(beaconing));
  endtask

  ////////////////////////////////////////
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_start();
    t_frag();
    t_rxack();
    t_txack();
    t_access();
    t_join();
    end_of_test();
  end
endmodule // tb_sf_scheduler

bind sf_scheduler sf_scheduler_monitor i_sf_scheduler_monitor (.mclk, .rst, .ce, .operating, .slot_index,
  .period, .awake, .tx_beacon, .tx_contention, .tx_reserved, .frag_sent, .frag_last, .frag_num,
  .rx_frame_ok, .rx_ack_pol, .rx_blk_req, .send_imm_ack, .send_blk_ack, .rx_ack, .ack_wait,
  .retransmit, .discard, .sf_start);
